// [verilog/acmf_top.sv]
`timescale 1ns/1ns
module acmf_top
  import acmf_pkg::*;
#(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_supply_ok,
  input wire logic i_run,
  input wire logic i_sleep_req,
  input wire logic i_wake_req,
  input wire logic [1:0] i_range,
  input wire logic i_self_test,
  input wire logic i_fast_read,
  input wire logic i_raw_valid,
  input wire logic signed [RAW_W-1:0] i_raw_x,
  input wire logic signed [RAW_W-1:0] i_raw_y,
  input wire logic signed [RAW_W-1:0] i_raw_z,
  output logic o_scl_oe_n,
  output logic o_sda_oe_n,
  output logic o_sda_out,
  output logic [3:0] o_mode,
  output logic o_analog_en,
  output logic o_sample_req,
  output logic o_data_ready,
  output logic signed [OUT_W-1:0] o_x,
  output logic signed [OUT_W-1:0] o_y,
  output logic signed [OUT_W-1:0] o_z
);

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_CYCLES_P - 1);

  typedef struct packed {
    acmf_mode_e mode;
    logic analog_en;
    logic [DIV_W-1:0] div;
    logic samp_req;
    logic dready;
    logic signed [OUT_W-1:0] x;
    logic signed [OUT_W-1:0] y;
    logic signed [OUT_W-1:0] z;
    acmf_bus_e bus;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic rw;
    logic nack;
    logic [2:0] idx;
    logic sda_oe_n;
    logic scl_oe_n;
  } acmf_state_s;

  acmf_state_s st;
  acmf_state_s next_st;
  acmf_pins_if pins ();

  acmf_pin_sync u_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_supply_ok(i_supply_ok),
    .pins(pins)
  );

  // Scale a 2 g-range count to the selected range and clip to 12 bits.
  function automatic logic signed [OUT_W-1:0] acmf_scale(
    input logic signed [RAW_W-1:0] raw,
    input logic signed [RAW_W-1:0] stim,
    input logic st_on,
    input logic [1:0] rng
  );
    logic signed [SUM_W-1:0] sum;
    logic signed [SUM_W-1:0] sc;
    sum = SUM_W'(raw) + (st_on ? SUM_W'(stim) : '0);
    unique case (rng)
      RANGE_4G: sc = sum >>> SHIFT_4G;
      RANGE_8G: sc = sum >>> SHIFT_8G;
      default: sc = sum;
    endcase
    acmf_scale = (sc > SUM_W'(OUT_MAX)) ? OUT_MAX :
        (sc < SUM_W'(OUT_MIN)) ? OUT_MIN : sc[OUT_W-1:0];
  endfunction

  // Byte of the output group; the low byte holds the four low bits on top.
  function automatic logic [7:0] acmf_byte(
    input logic [2:0] idx,
    input acmf_state_s s
  );
    unique case (idx)
      IDX_X_HI: acmf_byte = s.x[OUT_W-1:OUT_W-8];
      IDX_X_LO: acmf_byte = {s.x[3:0], 4'h0};
      IDX_Y_HI: acmf_byte = s.y[OUT_W-1:OUT_W-8];
      IDX_Y_LO: acmf_byte = {s.y[3:0], 4'h0};
      IDX_Z_HI: acmf_byte = s.z[OUT_W-1:OUT_W-8];
      default: acmf_byte = {s.z[3:0], 4'h0};
    endcase
  endfunction

  // Fast read walks the three high bytes only.
  function automatic logic [2:0] acmf_next_idx(
    input logic [2:0] idx,
    input logic fast
  );
    acmf_next_idx = fast ? ((idx >= IDX_Z_HI) ? IDX_X_HI : idx + 3'h2) :
        ((idx == IDX_Z_LO) ? IDX_X_HI : idx + 3'h1);
  endfunction

  logic [7:0] tx_byte;
  always_comb begin
    tx_byte = 8'h00;
    next_st = st;
    next_st.samp_req = 1'b0;
    next_st.scl_oe_n = 1'b1;
    unique case (st.mode)
      MODE_OFF: begin
        if (pins.supply_ok) begin
          next_st.mode = MODE_STANDBY;
        end
      end
      MODE_STANDBY: begin
        if (i_run) begin
          next_st.mode = MODE_WAKE;
          next_st.x = '0;
          next_st.y = '0;
          next_st.z = '0;
          next_st.dready = 1'b0;
          next_st.div = '0;
        end
      end
      MODE_WAKE: begin
        if (!i_run) begin
          next_st.mode = MODE_STANDBY;
        end else if (i_sleep_req) begin
          next_st.mode = MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        if (!i_run) begin
          next_st.mode = MODE_STANDBY;
        end else if (i_wake_req) begin
          next_st.mode = MODE_WAKE;
        end
      end
    endcase
    // Sampling runs only in ACTIVE; the divider is held otherwise.
    if (st.analog_en) begin
      if (st.div == DIV_LAST) begin
        next_st.div = '0;
        next_st.samp_req = 1'b1;
      end else begin
        next_st.div = st.div + 1'b1;
      end
      if (i_raw_valid) begin
        next_st.x = acmf_scale(i_raw_x, ST_X, i_self_test, i_range);
        next_st.y = acmf_scale(i_raw_y, ST_Y, i_self_test, i_range);
        next_st.z = acmf_scale(i_raw_z, ST_Z, i_self_test, i_range);
        next_st.dready = 1'b1;
      end
    end
    // Register reads stay available in STANDBY and ACTIVE.
    unique case (st.bus)
      BUS_IDLE: begin
        next_st.sda_oe_n = 1'b1;
      end
      BUS_ADDR: begin
        if (pins.scl_rise) begin
          next_st.shreg = {st.shreg[6:0], pins.sda};
          next_st.cnt = st.cnt + 4'h1;
        end else if (pins.scl_fall && st.cnt == BITS_PER_BYTE) begin
          if (st.shreg[7:1] == DEV_ADDR) begin
            next_st.bus = BUS_AACK;
            next_st.sda_oe_n = 1'b0;
            next_st.rw = st.shreg[0];
          end else begin
            next_st.bus = BUS_IDLE;
          end
        end
      end
      BUS_AACK: begin
        if (pins.scl_fall) begin
          next_st.cnt = 4'h1;
          if (st.rw) begin
            tx_byte = acmf_byte(IDX_X_HI, st);
            next_st.idx = IDX_X_HI;
            next_st.bus = BUS_TX;
            next_st.sda_oe_n = tx_byte[7];
            next_st.shreg = {tx_byte[6:0], 1'b0};
          end else begin
            next_st.bus = BUS_RX;
            next_st.cnt = 4'h0;
            next_st.sda_oe_n = 1'b1;
          end
        end
      end
      BUS_TX: begin
        if (pins.scl_fall) begin
          if (st.cnt == BITS_PER_BYTE) begin
            next_st.bus = BUS_TACK;
            next_st.sda_oe_n = 1'b1;
          end else begin
            next_st.sda_oe_n = st.shreg[7];
            next_st.shreg = {st.shreg[6:0], 1'b0};
            next_st.cnt = st.cnt + 4'h1;
          end
        end
      end
      BUS_TACK: begin
        if (pins.scl_rise) begin
          next_st.nack = pins.sda;
        end else if (pins.scl_fall) begin
          if (st.nack) begin
            next_st.bus = BUS_IDLE;
          end else begin
            next_st.idx = acmf_next_idx(st.idx, i_fast_read);
            tx_byte = acmf_byte(next_st.idx, st);
            next_st.bus = BUS_TX;
            next_st.cnt = 4'h1;
            next_st.sda_oe_n = tx_byte[7];
            next_st.shreg = {tx_byte[6:0], 1'b0};
          end
        end
      end
      BUS_RX: begin
        if (pins.scl_rise) begin
          next_st.cnt = st.cnt + 4'h1;
        end else if (pins.scl_fall && st.cnt == BITS_PER_BYTE) begin
          next_st.bus = BUS_RACK;
          next_st.sda_oe_n = 1'b0;
        end
      end
      BUS_RACK: begin
        if (pins.scl_fall) begin
          next_st.bus = BUS_RX;
          next_st.cnt = 4'h0;
          next_st.sda_oe_n = 1'b1;
        end
      end
    endcase
    if (pins.stop) begin
      next_st.bus = BUS_IDLE;
      next_st.sda_oe_n = 1'b1;
    end else if (pins.start) begin
      next_st.bus = BUS_ADDR;
      next_st.cnt = 4'h0;
      next_st.sda_oe_n = 1'b1;
    end
    // Losing core supply shuts every block and silences the bus.
    if (!pins.supply_ok) begin
      next_st.mode = MODE_OFF;
      next_st.bus = BUS_IDLE;
      next_st.sda_oe_n = 1'b1;
      next_st.x = '0;
      next_st.y = '0;
      next_st.z = '0;
      next_st.dready = 1'b0;
      next_st.div = '0;
    end else if (st.mode == MODE_OFF) begin
      next_st.bus = BUS_IDLE;
      next_st.sda_oe_n = 1'b1;
    end
    next_st.analog_en = next_st.mode inside {MODE_WAKE, MODE_SLEEP};
    next_st.samp_req = next_st.samp_req & next_st.analog_en;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{mode: MODE_OFF, bus: BUS_IDLE, sda_oe_n: 1'b1,
              scl_oe_n: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign o_scl_oe_n = st.scl_oe_n;
  assign o_sda_oe_n = st.sda_oe_n;
  assign o_sda_out = 1'b0;
  assign o_mode = st.mode;
  assign o_analog_en = st.analog_en;
  assign o_sample_req = st.samp_req;
  assign o_data_ready = st.dready;
  assign o_x = st.x;
  assign o_y = st.y;
  assign o_z = st.z;
endmodule

// [verilog/acmf_pkg.sv]
package acmf_pkg;

  localparam int CLK_PERIOD_NS = 50;
  // Output data rate of 800 Hz, one sample every 1250 us.
  localparam int SAMPLE_PERIOD_US = 1250;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int DIV_W = 16;

  // Bus address of the device; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h2a;

  localparam int RAW_W = 14;
  localparam int OUT_W = 12;
  localparam int SUM_W = 15;

  localparam logic [1:0] RANGE_2G = 2'h0;
  localparam logic [1:0] RANGE_4G = 2'h1;
  localparam logic [1:0] RANGE_8G = 2'h2;
  localparam int SHIFT_4G = 1;
  localparam int SHIFT_8G = 2;

  // Self-test stimulus per axis, in counts of the 2 g range.
  localparam logic signed [RAW_W-1:0] ST_X = 14'sh0040;
  localparam logic signed [RAW_W-1:0] ST_Y = 14'sh0040;
  localparam logic signed [RAW_W-1:0] ST_Z = 14'sh0080;

  localparam logic signed [OUT_W-1:0] OUT_MAX = 12'sh7ff;
  localparam logic signed [OUT_W-1:0] OUT_MIN = 12'sh800;

  // Output register group, lowest address first.
  localparam logic [2:0] IDX_X_HI = 3'h0;
  localparam logic [2:0] IDX_X_LO = 3'h1;
  localparam logic [2:0] IDX_Y_HI = 3'h2;
  localparam logic [2:0] IDX_Y_LO = 3'h3;
  localparam logic [2:0] IDX_Z_HI = 3'h4;
  localparam logic [2:0] IDX_Z_LO = 3'h5;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    MODE_OFF = 4'b0001,
    MODE_STANDBY = 4'b0010,
    MODE_WAKE = 4'b0100,
    MODE_SLEEP = 4'b1000
  } acmf_mode_e;

  typedef enum logic [6:0] {
    BUS_IDLE = 7'b0000001,
    BUS_ADDR = 7'b0000010,
    BUS_AACK = 7'b0000100,
    BUS_TX = 7'b0001000,
    BUS_TACK = 7'b0010000,
    BUS_RX = 7'b0100000,
    BUS_RACK = 7'b1000000
  } acmf_bus_e;

endpackage

// [verilog/acmf_pins_if.sv]
`timescale 1ns/1ns
interface acmf_pins_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic supply_ok;

  modport src (
    output scl, sda, scl_rise, scl_fall, start, stop, supply_ok
  );
  modport dst (
    input scl, sda, scl_rise, scl_fall, start, stop, supply_ok
  );
endinterface

// [verilog/acmf_pin_sync.sv]
`timescale 1ns/1ns
module acmf_pin_sync (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_supply_ok,
  acmf_pins_if.src pins
);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic sup_m;
    logic sup_s;
  } acmf_sync_s;

  acmf_sync_s st;
  acmf_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.scl_m = i_scl;
    next_st.scl_s = st.scl_m;
    next_st.scl_d = st.scl_s;
    next_st.sda_m = i_sda;
    next_st.sda_s = st.sda_m;
    next_st.sda_d = st.sda_s;
    next_st.sup_m = i_supply_ok;
    next_st.sup_s = st.sup_m;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
              sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
              sup_m: 1'b0, sup_s: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pins.scl = st.scl_s;
  assign pins.sda = st.sda_s;
  assign pins.scl_rise = st.scl_s & ~st.scl_d;
  assign pins.scl_fall = ~st.scl_s & st.scl_d;
  // Start and stop are data edges while the clock stays high.
  assign pins.start = st.scl_s & st.scl_d & ~st.sda_s & st.sda_d;
  assign pins.stop = st.scl_s & st.scl_d & st.sda_s & ~st.sda_d;
  assign pins.supply_ok = st.sup_s;

endmodule

// [bench/acmf_properties.sv]
`timescale 1ns/1ns
module acmf_properties
  import acmf_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic [1:0] i_range,
  input wire logic i_self_test,
  input wire logic i_raw_valid,
  input wire logic signed [RAW_W-1:0] i_raw_x,
  input wire logic signed [RAW_W-1:0] i_raw_y,
  input wire logic signed [RAW_W-1:0] i_raw_z,
  input wire logic o_scl_oe_n,
  input wire logic o_sda_oe_n,
  input wire logic [3:0] o_mode,
  input wire logic o_analog_en,
  input wire logic o_sample_req,
  input wire logic o_data_ready,
  input wire logic signed [OUT_W-1:0] o_x,
  input wire logic signed [OUT_W-1:0] o_y,
  input wire logic signed [OUT_W-1:0] o_z
);
  logic [1:0] sh;
  logic act;
  logic [11:0] ex, ey, ez;
  function automatic logic [11:0] clip(input logic signed [14:0] v);
    return v > 15'sh07ff ? 12'h7ff : v < -15'sh0800 ? 12'h800 : v[11:0];
  endfunction
  assign sh = i_range == RANGE_4G ? 2'h1 : i_range == RANGE_8G ? 2'h2 : 2'h0;
  assign act = o_mode == MODE_WAKE || o_mode == MODE_SLEEP;
  assign ex = clip((i_raw_x + (i_self_test ? ST_X : 14'sh0)) >>> sh);
  assign ey = clip((i_raw_y + (i_self_test ? ST_Y : 14'sh0)) >>> sh);
  assign ez = clip((i_raw_z + (i_self_test ? ST_Z : 14'sh0)) >>> sh);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_enter;
    o_mode == MODE_STANDBY ##1 o_mode == MODE_WAKE;
  endsequence
  sequence s_take;
    act && i_raw_valid;
  endsequence
  AST_SCL_FREE: assert property (o_scl_oe_n)
    else $error("clock line driven");
  AST_SCALE_X: assert property (s_take |=> o_x == $past(ex))
    else $error("x sample scaled wrongly");
  AST_SCALE_YZ: assert property (
    s_take |=> o_y == $past(ey) && o_z == $past(ez))
    else $error("y or z sample scaled wrongly");
  AST_READY: assert property (s_take |=> o_data_ready)
    else $error("data ready missing after sample");
  AST_STANDBY_IDLE: assert property (
    o_mode == MODE_STANDBY |-> !o_analog_en && !o_sample_req)
    else $error("analog path running in standby");
  AST_RUN_WAKE: assert property (
    o_mode == MODE_STANDBY && i_run |=> o_mode == MODE_WAKE && o_analog_en)
    else $error("run did not enter wake");
  AST_OFF_SILENT: assert property (
    o_mode == MODE_OFF [*2] |-> o_sda_oe_n && !o_analog_en)
    else $error("off device active");
  AST_ENTER_CLEAR: assert property (s_enter |->
    o_x == 12'h0 && o_y == 12'h0 && o_z == 12'h0 && !o_data_ready)
    else $error("outputs not cleared on entering active");
  AST_SUBMODE_RUN: assert property (act && !i_run |=> !act)
    else $error("sub-mode kept without run");
  AST_SLEEP_FROM_ACTIVE: assert property (
    o_mode == MODE_SLEEP |-> $past(act))
    else $error("sleep entered from outside active");
endmodule

bind acmf_top acmf_properties u_props (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_run(i_run),
  .i_range(i_range), .i_self_test(i_self_test), .i_raw_valid(i_raw_valid),
  .i_raw_x(i_raw_x), .i_raw_y(i_raw_y), .i_raw_z(i_raw_z),
  .o_scl_oe_n(o_scl_oe_n), .o_sda_oe_n(o_sda_oe_n), .o_mode(o_mode),
  .o_analog_en(o_analog_en), .o_sample_req(o_sample_req),
  .o_data_ready(o_data_ready), .o_x(o_x), .o_y(o_y), .o_z(o_z)
);

// [bench/acmf_host_model.sv]
`timescale 1ns/1ns
module acmf_host_model (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe_n
);
  int half = 200;
  initial begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
  end
  // Only the host moves the clock; it stays high between frames.
  task automatic put_bit(input logic b);
    o_sda_oe_n = b;
    #(half / 2);
    o_scl = 1'b1;
    #(half);
    o_scl = 1'b0;
    #(half / 2);
  endtask
  task automatic get_bit(output logic b);
    o_sda_oe_n = 1'b1;
    #(half / 2);
    o_scl = 1'b1;
    #(half / 2);
    b = i_sda;
    #(half / 2);
    o_scl = 1'b0;
    #(half / 2);
  endtask
  task automatic start();
    o_sda_oe_n = 1'b0;
    #(half);
    o_scl = 1'b0;
    #(half / 2);
  endtask
  task automatic stop();
    o_sda_oe_n = 1'b0;
    #(half / 2);
    o_scl = 1'b1;
    #(half);
    o_sda_oe_n = 1'b1;
    #(half * 2);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(ack);
  endtask
  task automatic recv(input logic nack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(nack);
  endtask
endmodule

// [bench/accel_mode_and_output_format_tb.sv]
`timescale 1ns/1ns
module accel_mode_and_output_format_tb;
  import acmf_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_supply_ok = 1'b1;
  logic i_run, i_sleep_req, i_wake_req, i_self_test, i_fast_read, i_raw_valid;
  logic [1:0] i_range;
  logic signed [RAW_W-1:0] i_raw_x, i_raw_y, i_raw_z;
  logic o_scl_oe_n, o_sda_oe_n, o_sda_out, o_analog_en, o_sample_req;
  logic o_data_ready;
  logic [3:0] o_mode;
  logic signed [OUT_W-1:0] o_x, o_y, o_z;
  logic host_scl, host_oe_n;
  wire logic sda_line = host_oe_n & (o_sda_oe_n | o_sda_out);
  logic [11:0] ex [3];
  int n_mismatch = 0;
  int check_count = 0;
  localparam int SAMP_P = 20;
  always #25 i_clock = ~i_clock;
  acmf_top #(.SAMPLE_CYCLES_P(SAMP_P)) DUT (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(host_scl & o_scl_oe_n),
    .i_sda(sda_line), .i_supply_ok(i_supply_ok), .i_run(i_run),
    .i_sleep_req(i_sleep_req), .i_wake_req(i_wake_req), .i_range(i_range),
    .i_self_test(i_self_test), .i_fast_read(i_fast_read),
    .i_raw_valid(i_raw_valid), .i_raw_x(i_raw_x), .i_raw_y(i_raw_y),
    .i_raw_z(i_raw_z), .o_scl_oe_n(o_scl_oe_n), .o_sda_oe_n(o_sda_oe_n),
    .o_sda_out(o_sda_out), .o_mode(o_mode), .o_analog_en(o_analog_en),
    .o_sample_req(o_sample_req), .o_data_ready(o_data_ready),
    .o_x(o_x), .o_y(o_y), .o_z(o_z));
  acmf_host_model host (.i_sda(sda_line), .o_scl(host_scl),
    .o_sda_oe_n(host_oe_n));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [11:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clock);
    #2;
  endtask
  task automatic wait_mode(input logic [3:0] m);
    int k;
    k = 0;
    while (o_mode !== m && k < 40) begin
      tick();
      k++;
    end
    chk("mode", o_mode, m);
    if (k == 40) end_sim();
  endtask
  function automatic logic [11:0] scale(input logic signed [13:0] raw,
      input logic signed [13:0] stim, input logic [1:0] rng);
    logic signed [14:0] s;
    s = (raw + stim) >>> (rng == 2'h1 ? 1 : rng == 2'h2 ? 2 : 0);
    return s > 15'sh07ff ? 12'h7ff : s < -15'sh0800 ? 12'h800 : s[11:0];
  endfunction
  task automatic t_sample(input logic [1:0] rng, input logic st,
      input logic signed [13:0] x, y, z);
    int k;
    i_run = 1'b0;
    tick(2);
    i_range = rng;
    i_self_test = st;
    i_run = 1'b1;
    tick();
    chk("mode", o_mode, MODE_WAKE);
    chk("ready0", o_data_ready, 1'b0);
    chk("x0", o_x, 12'h0);
    i_raw_x = x;
    i_raw_y = y;
    i_raw_z = z;
    i_raw_valid = 1'b1;
    tick();
    i_raw_valid = 1'b0;
    ex[0] = scale(x, st ? ST_X : 14'sh0, rng);
    ex[1] = scale(y, st ? ST_Y : 14'sh0, rng);
    ex[2] = scale(z, st ? ST_Z : 14'sh0, rng);
    chk("x", o_x, ex[0]);
    chk("y", o_y, ex[1]);
    chk("z", o_z, ex[2]);
    chk("ready", o_data_ready, 1'b1);
    k = 0;
    while (o_sample_req !== 1'b1 && k < 40) begin
      tick();
      k++;
    end
    chk("sample gap", 12'(k), 12'(SAMP_P - 1));
    if (k == 40) end_sim();
    tick();
    chk("sample pulse", o_sample_req, 1'b0);
    $display("test sample range %0d done", rng);
  endtask
  task automatic t_read(input logic fast);
    logic a;
    logic [7:0] b;
    int ax;
    i_fast_read = fast;
    host.start();
    host.send({DEV_ADDR, 1'b1}, a);
    chk("ack", a, 1'b0);
    for (int k = 0; k < (fast ? 3 : 6); k++) begin
      host.recv(k == (fast ? 2 : 5), b);
      ax = fast ? k : k / 2;
      chk("byte", b, (!fast && k[0]) ? {ex[ax][3:0], 4'h0} : ex[ax][11:4]);
    end
    host.stop();
    $display("test read fast %0d done", fast);
  endtask
  task automatic t_nack(input logic [6:0] adr);
    logic a;
    host.start();
    host.send({adr, 1'b1}, a);
    chk("nack", a, 1'b1);
    host.stop();
  endtask
  task automatic t_write(input logic [7:0] d);
    logic a;
    host.start();
    host.send({DEV_ADDR, 1'b0}, a);
    chk("wack", a, 1'b0);
    host.send(d, a);
    chk("dack", a, 1'b0);
    host.stop();
    $display("test write done");
  endtask
  task automatic t_modes();
    i_sleep_req = 1'b1;
    tick();
    i_sleep_req = 1'b0;
    wait_mode(MODE_SLEEP);
    chk("analog", o_analog_en, 1'b1);
    i_wake_req = 1'b1;
    tick();
    i_wake_req = 1'b0;
    wait_mode(MODE_WAKE);
    i_run = 1'b0;
    wait_mode(MODE_STANDBY);
    chk("analog", o_analog_en, 1'b0);
    i_sleep_req = 1'b1;
    tick(4);
    chk("mode", o_mode, MODE_STANDBY);
    i_sleep_req = 1'b0;
    t_write(8'h5a);
    t_nack(DEV_ADDR ^ 7'h01);
    i_supply_ok = 1'b0;
    wait_mode(MODE_OFF);
    t_nack(DEV_ADDR);
    i_supply_ok = 1'b1;
    wait_mode(MODE_STANDBY);
    $display("test modes done");
  endtask
  initial begin
    {i_run, i_sleep_req, i_wake_req, i_self_test, i_fast_read} = 5'h0;
    i_raw_valid = 1'b0;
    i_range = 2'h0;
    {i_raw_x, i_raw_y, i_raw_z} = '0;
    tick(12);
    i_rst_n = 1'b1;
    wait_mode(MODE_STANDBY);
    t_sample(2'h0, 1'b0, 14'sh0400, 14'sh3c00, 14'sh1000);
    t_sample(2'h1, 1'b0, 14'sh0400, 14'sh2000, 14'sh0fff);
    t_sample(2'h3, 1'b0, 14'sh0123, 14'sh3ffe, 14'sh07ff);
    t_read(1'b0);
    t_sample(2'h2, 1'b1, 14'sh0405, 14'sh0000, 14'sh3fff);
    host.half = 400;
    t_read(1'b1);
    host.half = 200;
    t_modes();
    end_sim();
  end
endmodule
